// ### hw/dir_entry_pkg.sv
// Constants and field layout for the directory-level entry decoder
// Notes on behaviour
// [R1] Entry bit 7 selects: 1 maps a 2-MByte page, 0 points to a table.
// [R2] Bit 8 of a page mapping is ignored, treated as zero.
// [R3] Set bit 6 after a write-needing request translates through a page mapping.
// [R4] Set bit 5 whenever either entry form takes part in a translation.
// [R5] Bits 4 and 3 steer memory type only for coherent-domain devices.
// [R6] Bit 2 clear denies user requests to the page or region.
// [R7] Bit 1 clear denies user writes, and supervisor writes under write protect.
// [R8] Bit 0 must be set for a valid page mapping.
// [R9] Bit 0 must be set to follow a table pointer.
// [R10] With no-execute enforcement, bit 63 set denies execute.
// [R11] Table pointer base is bits HOST_ADDR_WIDTH-1:12, guest-physical when type is nested.
// [R12] Bit 10 marks use only when extended-accessed tracking is enabled.
// [R13] Page frame address is bits HOST_ADDR_WIDTH-1:21, guest-physical when nested.
// [R14] Bit 12 joins bits 4 and 3 for coherent-domain memory type.
// [R15] Non-present or nonzero reserved bits give a reported translation fault.
// [R16] Ignored bits of both forms have no effect on the result.
package dir_entry_pkg;
	localparam int ENTRY_W = 64;
	localparam int ADDR_W = 52;
	localparam int HAW_DEFAULT = 48;
	localparam int BIT_PRESENT = 0;
	localparam int BIT_WRITE = 1;
	localparam int BIT_USER = 2;
	localparam int BIT_WT = 3;
	localparam int BIT_CD = 4;
	localparam int BIT_ACCESSED = 5;
	localparam int BIT_DIRTY = 6;
	localparam int BIT_SIZE = 7;
	localparam int BIT_GLOBAL = 8;
	localparam int BIT_EXT_ACC = 10;
	localparam int BIT_PAT = 12;
	localparam int PAGE_RSVD_LO = 13;
	localparam int PAGE_RSVD_HI = 20;
	localparam int PAGE_ADDR_LO = 21;
	localparam int TABLE_ADDR_LO = 12;
	localparam int BIT_NO_EXEC = 63;
	localparam logic [2:0] TT_NESTED = 3'h3;
	localparam logic [1:0] FLT_NONE = 2'h0;
	localparam logic [1:0] FLT_NOT_PRESENT = 2'h1;
	localparam logic [1:0] FLT_RESERVED = 2'h2;
	localparam logic [1:0] FLT_PERMISSION = 2'h3;
	localparam logic [63:0] ENTRY_RESET = 64'h0;
endpackage : dir_entry_pkg

// ### hw/dir_entry_perm.sv
// Permission check on one directory-level entry
`timescale 1ns/100ps
module dir_entry_perm (
	// Entry and request
	input wire logic [63:0] entry,
	input wire logic req_user,
	input wire logic req_write,
	input wire logic req_exec,
	// Context controls
	input wire logic write_protect_enforce,
	input wire logic no_exec_enforce,
	// Result
	output logic perm_ok
);
	// Combine the three independent denials
	always_comb begin
		perm_ok = 1'b1;
		if (req_user && !entry[dir_entry_pkg::BIT_USER]) perm_ok = 1'b0; // [R6]
		if (req_write && !entry[dir_entry_pkg::BIT_WRITE] && (req_user || write_protect_enforce)) perm_ok = 1'b0; // [R7]
		if (req_exec && no_exec_enforce && entry[dir_entry_pkg::BIT_NO_EXEC]) perm_ok = 1'b0; // [R10]
	end
endmodule : dir_entry_perm

// ### hw/dir_entry_fields.sv
// Address and attribute extraction from one directory-level entry
`timescale 1ns/100ps
module dir_entry_fields (
	// Entry and context
	input wire logic [63:0] entry,
	input wire logic [5:0] host_addr_width,
	// Extracted values
	output logic page_size_sel,
	output logic [51:0] out_addr,
	output logic rsvd_bad,
	output logic [2:0] mem_attr
);
	// Mask of address bits below the host address width
	function automatic logic [51:0] haw_mask(input logic [5:0] w);
		haw_mask = (52'h1 << w) - 52'h1;
	endfunction : haw_mask

	logic [51:0] lo_bits;
	assign lo_bits = entry[51:0];
	assign page_size_sel = entry[dir_entry_pkg::BIT_SIZE]; // [R1]
	// Address by entry form; bits 8, 9, 11 and 52..62 never reach any output
	always_comb begin
		if (page_size_sel) begin
			out_addr = lo_bits & haw_mask(host_addr_width) & ~52'h1fffff; // [R13]
			rsvd_bad = |(lo_bits & ~haw_mask(host_addr_width))
				| (|entry[dir_entry_pkg::PAGE_RSVD_HI:dir_entry_pkg::PAGE_RSVD_LO]); // [R15]
			mem_attr = {entry[dir_entry_pkg::BIT_PAT], entry[dir_entry_pkg::BIT_CD], entry[dir_entry_pkg::BIT_WT]}; // [R5] [R14]
		end else begin
			out_addr = lo_bits & haw_mask(host_addr_width) & ~52'hfff; // [R11]
			rsvd_bad = |(lo_bits & ~haw_mask(host_addr_width)); // [R15]
			mem_attr = 3'h0; // [R16]
		end
	end
endmodule : dir_entry_fields

// ### hw/first_stage_dir_entry_decode.sv
// Directory-level entry decoder for the first-stage walker
`timescale 1ns/100ps
module first_stage_dir_entry_decode (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Entry fetched from memory
	input wire logic entry_valid,
	input wire logic [63:0] directory_entry,
	// Request attributes
	input wire logic req_user,
	input wire logic req_write,
	input wire logic req_exec,
	input wire logic req_coherent,
	// Context entry controls
	input wire logic write_protect_enforce,
	input wire logic no_exec_enforce,
	input wire logic ext_accessed_enable,
	input wire logic [2:0] translation_type,
	input wire logic [5:0] host_addr_width,
	// Decode result
	output logic done_q,
	output logic fault_q,
	output logic [1:0] fault_code_q,
	output logic leaf_q,
	output logic [51:0] next_addr_q,
	output logic addr_is_guest_q,
	output logic [2:0] mem_attr_q,
	// Entry write-back
	output logic wb_valid_q,
	output logic [63:0] wb_entry_q
);
	////////////////////////////////////////////////////////////////
	logic page_size_sel;
	logic [51:0] addr_raw;
	logic rsvd_bad;
	logic [2:0] attr_raw;
	logic perm_ok;
	logic present;
	logic [1:0] fault_d;
	logic [63:0] upd_entry;

	dir_entry_fields dir_entry_fields_inst (
		.entry(directory_entry),
		.host_addr_width(host_addr_width),
		.page_size_sel(page_size_sel),
		.out_addr(addr_raw),
		.rsvd_bad(rsvd_bad),
		.mem_attr(attr_raw)
	);

	dir_entry_perm dir_entry_perm_inst (
		.entry(directory_entry),
		.req_user(req_user),
		.req_write(req_write),
		.req_exec(req_exec),
		.write_protect_enforce(write_protect_enforce),
		.no_exec_enforce(no_exec_enforce),
		.perm_ok(perm_ok)
	);

	////////////////////////////////////////////////////////////////
	// Fault priority: not present, then reserved, then permission
	assign present = directory_entry[dir_entry_pkg::BIT_PRESENT];
	always_comb begin
		if (!present) fault_d = dir_entry_pkg::FLT_NOT_PRESENT; // [R8] [R9]
		else if (rsvd_bad) fault_d = dir_entry_pkg::FLT_RESERVED; // [R15]
		else if (!perm_ok) fault_d = dir_entry_pkg::FLT_PERMISSION;
		else fault_d = dir_entry_pkg::FLT_NONE;
	end

	// Status bit update; global bit passes through untouched and unread
	always_comb begin
		upd_entry = directory_entry; // [R2]
		upd_entry[dir_entry_pkg::BIT_ACCESSED] = 1'b1; // [R4]
		if (ext_accessed_enable) upd_entry[dir_entry_pkg::BIT_EXT_ACC] = 1'b1; // [R12]
		if (page_size_sel && req_write) upd_entry[dir_entry_pkg::BIT_DIRTY] = 1'b1; // [R3]
	end

	////////////////////////////////////////////////////////////////
	// Result registers, one cycle after the entry arrives
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			done_q <= 1'b0;
			fault_q <= 1'b0;
			fault_code_q <= dir_entry_pkg::FLT_NONE;
			leaf_q <= 1'b0;
			next_addr_q <= 52'h0;
			addr_is_guest_q <= 1'b0;
			mem_attr_q <= 3'h0;
		end else begin
			done_q <= entry_valid;
			if (entry_valid) begin
				fault_q <= (fault_d != dir_entry_pkg::FLT_NONE); // [R15]
				fault_code_q <= fault_d;
				leaf_q <= page_size_sel; // [R1]
				next_addr_q <= (fault_d == dir_entry_pkg::FLT_NONE) ? addr_raw : 52'h0;
				addr_is_guest_q <= (translation_type == dir_entry_pkg::TT_NESTED); // [R11] [R13]
				// Non-coherent devices ignore the attribute bits
				mem_attr_q <= req_coherent ? attr_raw : 3'h0; // [R5] [R14]
			end
		end
	end

	// Write back only on success and only if a status bit really changes,
	// which saves a memory write on a repeated walk that finds those status bits already set
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			wb_valid_q <= 1'b0;
			wb_entry_q <= dir_entry_pkg::ENTRY_RESET;
		end else begin
			wb_valid_q <= entry_valid && (fault_d == dir_entry_pkg::FLT_NONE) && (upd_entry != directory_entry); // [R3] [R4]
			if (entry_valid) wb_entry_q <= upd_entry;
		end
	end
endmodule : first_stage_dir_entry_decode

// ### dv/entry_memory.sv
// Memory model holding directory-level entries
`timescale 1ns/100ps
module entry_memory (
	// Lookup
	input wire logic [2:0] idx,
	output logic [63:0] entry
);
	// Slot 2 left non-present so the walker must refuse it
	always_comb begin
		case (idx)
			3'h0: entry = 64'h0000_1234_5678_9007;
			3'h1: entry = 64'h8000_0000_0020_1197;
			3'h2: entry = 64'h0000_0000_0000_0086;
			3'h3: entry = 64'h0000_0000_0000_2087;
			3'h4: entry = 64'h0008_0000_0000_0007;
			3'h5: entry = 64'h0000_0000_0020_0085;
			default: entry = 64'h0000_0000_0000_0083;
		endcase
	end
endmodule : entry_memory

// ### dv/first_stage_dir_entry_decode_properties.sv
// Port checks of the directory-level entry decoder
`timescale 1ns/100ps
module first_stage_dir_entry_decode_properties (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Request side
	input wire logic entry_valid,
	input wire logic [63:0] directory_entry,
	input wire logic req_user,
	input wire logic req_exec,
	input wire logic req_coherent,
	input wire logic no_exec_enforce,
	// Result side
	input wire logic done_q,
	input wire logic fault_q,
	input wire logic [1:0] fault_code_q,
	input wire logic leaf_q,
	input wire logic [2:0] mem_attr_q,
	input wire logic wb_valid_q
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	//////////////////////////////////////
	// Answer comes exactly one cycle after the entry is taken
	answer_time_a: assert property (entry_valid |=> done_q) else $error("done late");
	done_pulse_a: assert property (!entry_valid |=> !done_q && !wb_valid_q) else $error("stray pulse");
	size_sel_a: assert property (entry_valid |=> leaf_q == $past(directory_entry[7])) else $error("size");
	absent_fault_a: assert property (entry_valid && !directory_entry[0] |=> fault_code_q == 2'h1) else $error("absent");
	user_deny_a: assert property (entry_valid && req_user && !directory_entry[2] |=> fault_q) else $error("user");
	exec_deny_a: assert property (entry_valid && req_exec && no_exec_enforce && directory_entry[63] |=> fault_q)
		else $error("exec");
	attr_zero_a: assert property (entry_valid && !(req_coherent && directory_entry[7]) |=> mem_attr_q == 3'h0)
		else $error("attr");
	fault_nowb_a: assert property (done_q && fault_q |-> !wb_valid_q) else $error("wb on fault");
	// Main scenarios reached
	cover property (done_q && leaf_q && !fault_q);
	cover property (done_q && fault_code_q == 2'h3);
	cover property (entry_valid ##1 entry_valid);
endmodule : first_stage_dir_entry_decode_properties
bind first_stage_dir_entry_decode first_stage_dir_entry_decode_properties props (.sys_clk, .arst_n, .entry_valid,
	.directory_entry, .req_user, .req_exec, .req_coherent, .no_exec_enforce, .done_q, .fault_q, .fault_code_q,
	.leaf_q, .mem_attr_q, .wb_valid_q);

// ### dv/first_stage_dir_entry_decode_bench.sv
// Self-checking bench of the directory-level entry decoder
`timescale 1ns/100ps
module first_stage_dir_entry_decode_bench;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic entry_valid = 1'b0;
	logic [2:0] idx = 3'h0;
	logic [7:0] ctl = 8'h0;
	logic [5:0] host_addr_width = 6'h30;
	logic [63:0] directory_entry, wb_entry_q;
	logic req_coherent, req_user, req_write, req_exec, write_protect_enforce, no_exec_enforce, ext_accessed_enable;
	logic done_q, fault_q, leaf_q, addr_is_guest_q, wb_valid_q;
	logic [1:0] fault_code_q;
	logic [51:0] next_addr_q;
	logic [2:0] mem_attr_q, translation_type;
	int errors = 0;
	int n_checks = 0;
	int cycles = 0;
	// Rows: slot, controls {coh,nest,user,write,exec,wpe,nxe,eae}, fault code
	logic [12:0] rows [13] = '{13'h0104, 13'h0080, 13'h0640, 13'h042b, 13'h0620, 13'h0801, 13'h0c02, 13'h1002,
		13'h1440, 13'h1453, 13'h14c3, 13'h1883, 13'h1800};
	assign {req_user, req_write, req_exec, write_protect_enforce, no_exec_enforce, ext_accessed_enable} = ctl[5:0];
	assign req_coherent = ctl[7];
	assign translation_type = {1'b0, ctl[6], ctl[6]};
	//////////////////////////////////////
	entry_memory entry_memory_inst (.idx, .entry(directory_entry));
	first_stage_dir_entry_decode first_stage_dir_entry_decode_inst (.sys_clk, .arst_n, .entry_valid, .directory_entry,
		.req_user, .req_write, .req_exec, .req_coherent, .write_protect_enforce, .no_exec_enforce, .ext_accessed_enable,
		.translation_type, .host_addr_width, .done_q, .fault_q, .fault_code_q, .leaf_q, .next_addr_q, .addr_is_guest_q,
		.mem_attr_q, .wb_valid_q, .wb_entry_q);
	// Clock and a hang guard well above the run length
	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 200) begin
			errors++;
			wrap_up();
		end
	end
	//////////////////////////////////////
	task automatic cmp(input string name, input logic [63:0] exp, input logic [63:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : cmp
	// One request, checked while done stands, then an idle cycle
	task automatic run(input logic [12:0] r);
		logic [63:0] e;
		logic [63:0] w;
		idx = r[12:10];
		ctl = r[9:2];
		entry_valid = 1'b1;
		@(negedge sys_clk);
		e = directory_entry;
		w = e | 64'h20 | (64'(ctl[0]) << 10) | (64'(e[7] & ctl[4]) << 6);
		cmp("code", 64'({1'b1, r[1:0] != 2'h0, r[1:0]}), 64'({done_q, fault_q, fault_code_q}));
		if (r[1:0] == 2'h0) begin
			cmp("addr", 64'(e[7] ? {e[51:21], 21'h0} : {e[51:12], 12'h0}), 64'(next_addr_q));
			cmp("wb", w, wb_entry_q);
			cmp("wbv", 64'(w != e), 64'(wb_valid_q));
			cmp("attr", 64'((e[7] & ctl[7]) ? {e[12], e[4], e[3]} : 3'h0), 64'(mem_attr_q));
			cmp("guest", 64'(ctl[6]), 64'(addr_is_guest_q));
		end else begin
			cmp("wbv", 64'h0, 64'(wb_valid_q));
		end
		entry_valid = 1'b0;
		@(negedge sys_clk);
	endtask : run
	task automatic wrap_up();
		if (errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up
	//////////////////////////////////////
	// Table, then back-to-back, narrow address width and reset in mid-run
	initial begin
		repeat (4) @(negedge sys_clk);
		arst_n = 1'b1;
		for (int i = 0; i < 13; i++) run(rows[i]);
		idx = 3'h0;
		entry_valid = 1'b1;
		@(negedge sys_clk);
		cmp("b2b0", 64'h2, 64'({done_q, leaf_q}));
		idx = 3'h1;
		@(negedge sys_clk);
		cmp("b2b1", 64'h3, 64'({done_q, leaf_q}));
		entry_valid = 1'b0;
		@(negedge sys_clk);
		host_addr_width = 6'h28;
		run(13'h0002);
		arst_n = 1'b0;
		#1;
		cmp("reset", 64'h0, 64'({done_q, wb_valid_q, fault_q, leaf_q, next_addr_q}));
		// Release again and make sure the decoder comes back quiet, then works
		@(negedge sys_clk);
		arst_n = 1'b1;
		host_addr_width = 6'h30;
		@(negedge sys_clk);
		cmp("idle", 64'h0, 64'({done_q, wb_valid_q, fault_q}));
		run(13'h0640);
		wrap_up();
	end
endmodule : first_stage_dir_entry_decode_bench
